//--- src/timer_slave_pkg.sv
package timer_slave_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;

   // *************************************************
   // register offsets
   // *************************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_SLAVE = 4'h1;
   localparam logic [3:0] ADDR_INPUT = 4'h2;
   localparam logic [3:0] ADDR_PSC = 4'h3;
   localparam logic [3:0] ADDR_ARR = 4'h4;
   localparam logic [3:0] ADDR_CNT = 4'h5;
   localparam logic [3:0] ADDR_CAPTURE = 4'h6;
   localparam logic [3:0] ADDR_FLAG = 4'h7;
   localparam logic [3:0] ADDR_CFG = 4'h8;
   localparam logic [3:0] ADDR_EVENT = 4'h9;
   localparam logic [3:0] ADDR_CCR = 4'ha;

   // *************************************************
   // field positions
   // *************************************************
   localparam int CTRL_CEN = 0;
   localparam int CTRL_DIR = 1;
   localparam int CTRL_URS = 2;
   localparam int CTRL_XOR = 3;
   localparam int CTRL_ARBE = 4;
   localparam int SMS_LSB = 0;
   localparam int SMS_W = 3;
   localparam int TS_LSB = 4;
   localparam int TS_W = 3;
   localparam int ETF_LSB = 8;
   localparam int FILT_W = 4;
   localparam int ETPS_LSB = 12;
   localparam int ETPS_W = 2;
   localparam int SLV_ECE = 14;
   localparam int SLV_ETP = 15;
   localparam int IN_CC1P = 0;
   localparam int IN_CC2P = 1;
   localparam int IC1F_LSB = 4;
   localparam int IC2F_LSB = 8;
   localparam int CC1S_LSB = 12;
   localparam int CCS_W = 2;
   localparam int FLAG_TRIG = 0;
   localparam int FLAG_UPD = 1;
   localparam int FLAG_CAP = 2;
   localparam int FLAG_W = 3;
   localparam int EVT_UG = 0;

   // *************************************************
   // codes and reset values
   // *************************************************
   localparam logic [2:0] SMS_OFF = 3'h0;
   localparam logic [2:0] SMS_ENC_TWO = 3'h1;
   localparam logic [2:0] SMS_ENC_ONE = 3'h2;
   localparam logic [2:0] SMS_ENC_BOTH = 3'h3;
   localparam logic [2:0] SMS_RESET = 3'h4;
   localparam logic [2:0] SMS_GATED = 3'h5;
   localparam logic [2:0] SMS_TRIGGER = 3'h6;
   localparam logic [2:0] SMS_EXT_ONE = 3'h7;
   localparam logic [2:0] TS_INTERNAL = 3'h0;
   localparam logic [2:0] TS_FILT_ONE = 3'h5;
   localparam logic [2:0] TS_FILT_TWO = 3'h6;
   localparam logic [2:0] TS_EXTERNAL = 3'h7;
   localparam logic [3:0] FILTER_OFF = 4'h0;
   localparam logic [1:0] CAP_DIRECT = 2'h1;
   localparam logic [15:0] WORD_ZERO = 16'h0;
   localparam logic [15:0] WORD_ONE = 16'h1;
   localparam logic [15:0] ARR_RESET = 16'hffff;
   localparam logic [2:0] ETR_DIV_ZERO = 3'h0;
endpackage

//--- src/input_conditioner.sv
`timescale 1ns/1ps
module input_conditioner
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   input wire logic [3:0] filter_i,
   input wire logic invert_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic sync_a;
   logic sync_b;
   logic stable;
   logic [3:0] count;
   logic prev;
   logic next_stable;
   logic [3:0] next_count;

   // *************************************************
   // filter: a change must persist filter_i+1 samples
   // *************************************************
   always_comb
   begin
      next_stable = stable;
      next_count = timer_slave_pkg::FILTER_OFF;
      if (sync_b != stable)
      begin
         if (count >= filter_i)
            next_stable = sync_b;
         else
            next_count = count + 4'h1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         stable <= 1'b0;
         count <= 4'h0;
         prev <= 1'b0;
      end
      else
      begin
         sync_a <= pin_i;
         sync_b <= sync_a;
         stable <= next_stable;
         count <= next_count;
         prev <= level_o;
      end
   end

   assign level_o = stable ^ invert_i;
   // edges seen in the same cycle the level settles; a polarity flip shows as an edge
   assign rise_o = level_o & ~prev;
   assign fall_o = ~level_o & prev;
endmodule

//--- src/etr_prescaler.sv
`timescale 1ns/1ps
module etr_prescaler
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic level_i,
   input wire logic [1:0] div_i,
   output logic tick_o
);
   logic prev;
   logic [2:0] count;
   logic tick;
   logic [2:0] next_count;
   logic next_tick;
   logic [2:0] limit;

   assign limit = 3'((4'h1 << div_i) - 4'h1);

   always_comb
   begin
      next_count = count;
      next_tick = 1'b0;
      if (level_i & ~prev)
      begin
         // code 00 gives limit 0: every edge ticks
         if (count >= limit)
         begin
            next_count = timer_slave_pkg::ETR_DIV_ZERO;
            next_tick = 1'b1;
         end
         else
            next_count = count + 3'h1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prev <= 1'b0;
         count <= 3'h0;
         tick <= 1'b0;
      end
      else
      begin
         prev <= level_i;
         count <= next_count;
         tick <= next_tick;
      end
   end

   assign tick_o = tick;
endmodule

//--- src/timer_slave_encoder_control.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module timer_slave_encoder_control
(
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic [3:0] REG_ADDR_I,
   input wire logic [15:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [15:0] REG_RDATA_O,
   input wire logic TIMER_INPUT_ONE_I,
   input wire logic TIMER_INPUT_TWO_I,
   input wire logic TIMER_INPUT_THREE_I,
   input wire logic TIMER_INPUT_FOUR_I,
   input wire logic EXTERNAL_TRIGGER_SIGNAL_I,
   input wire logic INTERNAL_TRIGGER_ZERO_I,
   output logic TRIGGER_OUTPUT_O,
   output logic [15:0] COUNT_O,
   output logic COMPARE_MATCH_O,
   output logic TIMER_IRQ_O
);
   logic [15:0] ctrl;
   logic [15:0] slave;
   logic [15:0] inputs;
   logic [15:0] psc;
   logic [15:0] psc_cnt;
   logic [15:0] arr_buf;
   logic [15:0] arr_sh;
   logic [15:0] ccr_buf;
   logic [15:0] ccr_sh;
   logic [15:0] cnt;
   logic [15:0] capture;
   logic [2:0] flags;
   logic [2:0] cfg;
   logic [15:0] rdata;
   logic trigger_input_prev;
   logic trg_out;
   logic match;
   logic irq;
   logic [15:0] next_ctrl;
   logic [15:0] next_slave;
   logic [15:0] next_inputs;
   logic [15:0] next_psc;
   logic [15:0] next_psc_cnt;
   logic [15:0] next_arr_buf;
   logic [15:0] next_arr_sh;
   logic [15:0] next_ccr_buf;
   logic [15:0] next_ccr_sh;
   logic [15:0] next_cnt;
   logic [15:0] next_capture;
   logic [2:0] next_flags;
   logic [2:0] next_cfg;
   logic [15:0] next_rdata;
   logic [2:0] flag_set;
   logic ug;
   logic cnt_wr;
   logic uev;
   logic raw_tick;
   logic cnt_tick;
   logic reset_trig;
   logic wrap_up;

   logic [2:0] sms;
   logic [2:0] ts;
   logic enc_mode;
   logic ti1_src;
   logic l1, r1, f1;
   logic l2, r2, f2;
   logic etr_level;
   logic etr_tick;
   logic t1e, t2e;
   logic up1, up2;
   logic enc_dir;
   logic enc_tick;
   logic count_dir;
   logic trigger_input;
   logic trg_edge;
   logic trg_fall;

   localparam int CC1S_HI = timer_slave_pkg::CC1S_LSB + timer_slave_pkg::CCS_W - 1;

   // *************************************************
   // input paths
   // *************************************************
   assign sms = slave[timer_slave_pkg::SMS_LSB +: timer_slave_pkg::SMS_W];
   assign ts = slave[timer_slave_pkg::TS_LSB +: timer_slave_pkg::TS_W];
   // xor of async pins ahead of the synchroniser; glitches are absorbed there
   assign ti1_src = ctrl[timer_slave_pkg::CTRL_XOR] ?
      (TIMER_INPUT_TWO_I ^ TIMER_INPUT_THREE_I ^ TIMER_INPUT_FOUR_I) : TIMER_INPUT_ONE_I;

   input_conditioner cond_one
   (
      .clock_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .pin_i(ti1_src),
      .filter_i(inputs[timer_slave_pkg::IC1F_LSB +: timer_slave_pkg::FILT_W]),
      .invert_i(inputs[timer_slave_pkg::IN_CC1P]),
      .level_o(l1),
      .rise_o(r1),
      .fall_o(f1)
   );

   input_conditioner cond_two
   (
      .clock_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .pin_i(TIMER_INPUT_TWO_I),
      .filter_i(inputs[timer_slave_pkg::IC2F_LSB +: timer_slave_pkg::FILT_W]),
      .invert_i(inputs[timer_slave_pkg::IN_CC2P]),
      .level_o(l2),
      .rise_o(r2),
      .fall_o(f2)
   );

   input_conditioner cond_ext
   (
      .clock_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .pin_i(EXTERNAL_TRIGGER_SIGNAL_I),
      .filter_i(slave[timer_slave_pkg::ETF_LSB +: timer_slave_pkg::FILT_W]),
      .invert_i(slave[timer_slave_pkg::SLV_ETP]),
      .level_o(etr_level),
      .rise_o(),
      .fall_o()
   );

   etr_prescaler ext_div
   (
      .clock_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .level_i(etr_level),
      .div_i(slave[timer_slave_pkg::ETPS_LSB +: timer_slave_pkg::ETPS_W]),
      .tick_o(etr_tick)
   );

   // *************************************************
   // encoder decode
   // *************************************************
   assign enc_mode = (sms == timer_slave_pkg::SMS_ENC_TWO) || (sms == timer_slave_pkg::SMS_ENC_ONE) ||
      (sms == timer_slave_pkg::SMS_ENC_BOTH);
   assign t1e = r1 | f1;
   assign t2e = r2 | f2;
   assign up1 = (r1 & ~l2) | (f1 & l2);
   assign up2 = (r2 & l1) | (f2 & ~l1);
   // dir 1 means down; input one wins if both move together
   assign enc_dir = t1e ? ~up1 : (t2e ? ~up2 : ctrl[timer_slave_pkg::CTRL_DIR]);
   assign enc_tick = ctrl[timer_slave_pkg::CTRL_CEN] &
      (((sms == timer_slave_pkg::SMS_ENC_TWO) & t2e) |
       ((sms == timer_slave_pkg::SMS_ENC_ONE) & t1e) |
       ((sms == timer_slave_pkg::SMS_ENC_BOTH) & (t1e | t2e)));
   assign count_dir = enc_mode ? enc_dir : ctrl[timer_slave_pkg::CTRL_DIR];

   // *************************************************
   // trigger selection
   // *************************************************
   always_comb
   begin
      case (ts)
         timer_slave_pkg::TS_INTERNAL: trigger_input = INTERNAL_TRIGGER_ZERO_I;
         timer_slave_pkg::TS_FILT_ONE: trigger_input = l1;
         timer_slave_pkg::TS_FILT_TWO: trigger_input = l2;
         timer_slave_pkg::TS_EXTERNAL: trigger_input = etr_level;
         default: trigger_input = 1'b0;
      endcase
   end

   assign trg_edge = trigger_input & ~trigger_input_prev;
   assign trg_fall = ~trigger_input & trigger_input_prev;
   assign reset_trig = (sms == timer_slave_pkg::SMS_RESET) & trg_edge;

   // *************************************************
   // registers and counter
   // *************************************************
   always_comb
   begin
      next_ctrl = ctrl;
      next_slave = slave;
      next_inputs = inputs;
      next_psc = psc;
      next_arr_buf = arr_buf;
      next_ccr_buf = ccr_buf;
      next_cfg = cfg;
      next_psc_cnt = psc_cnt;
      next_cnt = cnt;
      next_capture = capture;
      next_rdata = timer_slave_pkg::WORD_ZERO;
      flag_set = 3'h0;
      next_flags = flags;
      ug = 1'b0;
      cnt_wr = 1'b0;
      uev = 1'b0;
      cnt_tick = 1'b0;
      wrap_up = 1'b0;
      if (REG_WR_I)
      begin
         if (REG_ADDR_I == timer_slave_pkg::ADDR_CTRL)
            next_ctrl = REG_WDATA_I;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_SLAVE)
            next_slave = REG_WDATA_I;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_INPUT)
            next_inputs = REG_WDATA_I;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_PSC)
            next_psc = REG_WDATA_I;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_ARR)
            next_arr_buf = REG_WDATA_I;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_CCR)
            next_ccr_buf = REG_WDATA_I;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_CNT)
            cnt_wr = 1'b1;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_CFG)
            next_cfg = REG_WDATA_I[timer_slave_pkg::FLAG_W-1:0];
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_FLAG)
            next_flags = flags & ~REG_WDATA_I[timer_slave_pkg::FLAG_W-1:0];
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_EVENT)
            ug = REG_WDATA_I[timer_slave_pkg::EVT_UG];
      end
      // hardware beats a software write in the same cycle, except a counter write, which wins over the count
      if (enc_mode & (t1e | t2e))
         next_ctrl[timer_slave_pkg::CTRL_DIR] = enc_dir;
      if ((sms == timer_slave_pkg::SMS_TRIGGER) & trg_edge)
      begin
         next_ctrl[timer_slave_pkg::CTRL_CEN] = 1'b1;
         flag_set[timer_slave_pkg::FLAG_TRIG] = 1'b1;
      end
      if (reset_trig)
         flag_set[timer_slave_pkg::FLAG_TRIG] = 1'b1;
      if ((sms == timer_slave_pkg::SMS_GATED) & ctrl[timer_slave_pkg::CTRL_CEN] & (trg_edge | trg_fall))
         flag_set[timer_slave_pkg::FLAG_TRIG] = 1'b1;
      // tick source ahead of the prescaler
      if (enc_mode)
         raw_tick = enc_tick;
      else if (sms == timer_slave_pkg::SMS_EXT_ONE)
         raw_tick = ctrl[timer_slave_pkg::CTRL_CEN] & trg_edge;
      else
         raw_tick = ctrl[timer_slave_pkg::CTRL_CEN] &
            ((sms != timer_slave_pkg::SMS_GATED) | trigger_input) &
            (~slave[timer_slave_pkg::SLV_ECE] | etr_tick);
      if (raw_tick)
      begin
         if (psc_cnt >= psc)
         begin
            next_psc_cnt = timer_slave_pkg::WORD_ZERO;
            cnt_tick = 1'b1;
         end
         else
            next_psc_cnt = psc_cnt + timer_slave_pkg::WORD_ONE;
      end
      if (reset_trig | ug)
      begin
         next_psc_cnt = timer_slave_pkg::WORD_ZERO;
         next_cnt = count_dir ? arr_sh : timer_slave_pkg::WORD_ZERO;
         uev = ug | ~ctrl[timer_slave_pkg::CTRL_URS];
      end
      else if (cnt_tick)
      begin
         if (count_dir)
         begin
            if (cnt == timer_slave_pkg::WORD_ZERO)
            begin
               next_cnt = arr_sh;
               uev = 1'b1;
            end
            else
               next_cnt = cnt - timer_slave_pkg::WORD_ONE;
         end
         else if (cnt >= arr_sh)
         begin
            next_cnt = timer_slave_pkg::WORD_ZERO;
            uev = 1'b1;
            wrap_up = ~cnt_wr;
         end
         else
            next_cnt = cnt + timer_slave_pkg::WORD_ONE;
      end
      if (cnt_wr)
         next_cnt = REG_WDATA_I;
      flag_set[timer_slave_pkg::FLAG_UPD] = uev;
      // capture on own pin path only; other mappings are not built
      if ((inputs[CC1S_HI:timer_slave_pkg::CC1S_LSB] == timer_slave_pkg::CAP_DIRECT) & r1)
      begin
         next_capture = cnt;
         flag_set[timer_slave_pkg::FLAG_CAP] = 1'b1;
      end
      next_flags = next_flags | flag_set;
      next_arr_sh = (uev | ~next_ctrl[timer_slave_pkg::CTRL_ARBE]) ? next_arr_buf : arr_sh;
      next_ccr_sh = uev ? next_ccr_buf : ccr_sh;
      if (REG_RD_I)
      begin
         if (REG_ADDR_I == timer_slave_pkg::ADDR_CTRL)
            next_rdata = ctrl;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_SLAVE)
            next_rdata = slave;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_INPUT)
            next_rdata = inputs;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_PSC)
            next_rdata = psc;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_ARR)
            next_rdata = arr_buf;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_CCR)
            next_rdata = ccr_buf;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_CNT)
            next_rdata = cnt;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_CAPTURE)
            next_rdata = capture;
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_FLAG)
            next_rdata = {13'h0, flags};
         else if (REG_ADDR_I == timer_slave_pkg::ADDR_CFG)
            next_rdata = {13'h0, cfg};
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         ctrl <= 16'h0;
         slave <= 16'h0;
         inputs <= 16'h0;
         psc <= 16'h0;
         psc_cnt <= 16'h0;
         arr_buf <= timer_slave_pkg::ARR_RESET;
         arr_sh <= timer_slave_pkg::ARR_RESET;
         ccr_buf <= 16'h0;
         ccr_sh <= 16'h0;
         cnt <= 16'h0;
         capture <= 16'h0;
         flags <= 3'h0;
         cfg <= 3'h0;
         rdata <= 16'h0;
         trigger_input_prev <= 1'b0;
         trg_out <= 1'b0;
         match <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         slave <= next_slave;
         inputs <= next_inputs;
         psc <= next_psc;
         psc_cnt <= next_psc_cnt;
         arr_buf <= next_arr_buf;
         arr_sh <= next_arr_sh;
         ccr_buf <= next_ccr_buf;
         ccr_sh <= next_ccr_sh;
         cnt <= next_cnt;
         capture <= next_capture;
         flags <= next_flags;
         cfg <= next_cfg;
         rdata <= next_rdata;
         trigger_input_prev <= trigger_input;
         trg_out <= uev;
         match <= (next_cnt == next_ccr_sh);
         irq <= |(next_flags & next_cfg);
      end
   end

   assign REG_RDATA_O = rdata;
   assign TRIGGER_OUTPUT_O = trg_out;
   assign COUNT_O = cnt;
   assign COMPARE_MATCH_O = match;
   assign TIMER_IRQ_O = irq;

   // *************************************************
   // checks
   // *************************************************
   chk_reset_flag: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      reset_trig |=> flags[timer_slave_pkg::FLAG_TRIG])
      else $error("reset trigger did not set trigger flag");
   chk_reset_clear: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (reset_trig && !count_dir && !cnt_wr) |=> (cnt == 16'h0) && (psc_cnt == 16'h0))
      else $error("reset trigger did not clear counter");
   chk_reset_update: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (reset_trig && !ctrl[timer_slave_pkg::CTRL_URS]) |=> TRIGGER_OUTPUT_O)
      else $error("reset trigger gave no update");
   chk_gated_hold: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (sms == timer_slave_pkg::SMS_GATED && !ctrl[timer_slave_pkg::CTRL_CEN] && !REG_WR_I) |=> $stable(cnt))
      else $error("gated counter moved while disabled");
   chk_gated_idle: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (sms == timer_slave_pkg::SMS_GATED && !trigger_input && !REG_WR_I) |=> $stable(cnt))
      else $error("gated counter moved with gate inactive");
   chk_trig_start: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (sms == timer_slave_pkg::SMS_TRIGGER && trg_edge) |=>
         ctrl[timer_slave_pkg::CTRL_CEN] && flags[timer_slave_pkg::FLAG_TRIG])
      else $error("trigger edge did not start counter");
   chk_enc_one_dir: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (enc_mode && r1 && l2) |=> ctrl[timer_slave_pkg::CTRL_DIR])
      else $error("input one rise with two high not down");
   chk_enc_two_dir: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (enc_mode && r2 && l1 && !t1e) |=> !ctrl[timer_slave_pkg::CTRL_DIR])
      else $error("input two rise with one high not up");
   chk_enc_select: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (sms == timer_slave_pkg::SMS_ENC_TWO && t1e && !t2e && !REG_WR_I) |=> $stable(cnt))
      else $error("unselected encoder input counted");
   chk_wrap_zero: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      wrap_up |=> (cnt == 16'h0) && TRIGGER_OUTPUT_O)
      else $error("up count did not wrap to zero");
endmodule

//--- sim/quad_encoder_model.sv
`timescale 1ns/1ps
module quad_encoder_model
(
   input wire logic clock_i,
   input wire logic step_i,
   input wire logic fwd_i,
   output logic a_o,
   output logic b_o
);
   // ************************************
   // gray code walk of a quadrature disc
   // ************************************
   logic [1:0] phase;
   initial phase = 2'h0;
   // one line moves per step, never both at once, so direction is never ambiguous
   always @(posedge clock_i)
   begin
      if (step_i)
         phase <= fwd_i ? phase + 2'h1 : phase - 2'h1;
   end
   // forward order 00, 10, 11, 01: line a leads
   assign a_o = phase[0] ^ phase[1];
   assign b_o = phase[1];
endmodule

//--- sim/timer_slave_encoder_control_tb.sv
`timescale 1ns/1ps
module timer_slave_encoder_control_tb;
   logic clk, rst_n, wr, rd, step, fwd, a, b, trg, cmp, irq;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, cnt, got;
   int n_fail, compares, cycles;
   timer_slave_encoder_control dut (.CLOCK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .TIMER_INPUT_ONE_I(a), .TIMER_INPUT_TWO_I(b),
      .TIMER_INPUT_THREE_I(1'b0), .TIMER_INPUT_FOUR_I(1'b0), .EXTERNAL_TRIGGER_SIGNAL_I(1'b0),
      .INTERNAL_TRIGGER_ZERO_I(1'b0), .TRIGGER_OUTPUT_O(trg), .COUNT_O(cnt), .COMPARE_MATCH_O(cmp),
      .TIMER_IRQ_O(irq));
   quad_encoder_model enc (.clock_i(clk), .step_i(step), .fwd_i(fwd), .a_o(a), .b_o(b));
   // ************************************
   // clock, reset and hang guard
   // ************************************
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         test_done();
      end
   end
   // ************************************
   // shared tasks
   // ************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] ad, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= ad;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] ad);
      @(posedge clk);
      rd <= 1'b1;
      addr <= ad;
      @(posedge clk);
      rd <= 1'b0;
      // data stands only in the cycle after the strobe
      #1 got = rdata;
   endtask
   // each step moves one line; 8 cycles covers sync, filter and count latency
   task automatic turn(input logic f, input int n);
      repeat (n)
      begin
         @(posedge clk);
         step <= 1'b1;
         fwd <= f;
         @(posedge clk);
         step <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask
   task automatic test_done();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ************************************
   // scenarios
   // ************************************
   task automatic t_reset_values();
      rreg(timer_slave_pkg::ADDR_ARR);
      chk(got, timer_slave_pkg::ARR_RESET);
      chk(cnt, timer_slave_pkg::WORD_ZERO);
      $display("test reset values done");
   endtask
   task automatic t_encoder_both();
      wreg(timer_slave_pkg::ADDR_ARR, 16'h0005);
      wreg(timer_slave_pkg::ADDR_INPUT, 16'h5000);
      wreg(timer_slave_pkg::ADDR_SLAVE, 16'h0003);
      wreg(timer_slave_pkg::ADDR_CTRL, 16'h0001);
      turn(1'b1, 3);
      chk(cnt, 16'h0003);
      // going back past zero must wrap to the reload value
      turn(1'b0, 4);
      chk(cnt, 16'h0005);
      rreg(timer_slave_pkg::ADDR_CTRL);
      chk(got, 16'h0003);
      $display("test encoder both edges done");
   endtask
   task automatic t_encoder_one();
      wreg(timer_slave_pkg::ADDR_SLAVE, 16'h0002);
      // first step moves line b only: direction flips, count holds
      turn(1'b1, 1);
      chk(cnt, 16'h0005);
      rreg(timer_slave_pkg::ADDR_CTRL);
      chk(got, 16'h0001);
      turn(1'b1, 3);
      chk(cnt, 16'h0001);
      $display("test encoder input one done");
   endtask
   task automatic t_trigger_start();
      int n_trg;
      int n_cmp;
      wreg(timer_slave_pkg::ADDR_CTRL, 16'h0000);
      // source first, mode after: a source switch alone can look like an edge
      wreg(timer_slave_pkg::ADDR_SLAVE, 16'h0060);
      wreg(timer_slave_pkg::ADDR_SLAVE, 16'h0066);
      wreg(timer_slave_pkg::ADDR_FLAG, 16'h0007);
      wreg(timer_slave_pkg::ADDR_CFG, 16'h0001);
      repeat (3) @(posedge clk);
      chk({15'h0, irq}, 16'h0000);
      // b falls, a rises, then b rises: only the last is the selected edge
      turn(1'b1, 2);
      rreg(timer_slave_pkg::ADDR_CTRL);
      chk(got, 16'h0000);
      turn(1'b1, 1);
      rreg(timer_slave_pkg::ADDR_CTRL);
      chk(got, 16'h0001);
      rreg(timer_slave_pkg::ADDR_FLAG);
      chk(got & 16'h0001, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      // free running over reload 5: one update and one zero match every 6 cycles
      n_trg = 0;
      n_cmp = 0;
      repeat (12)
      begin
         @(posedge clk);
         #1 n_trg += int'(trg);
         n_cmp += int'(cmp);
      end
      chk(16'(n_trg), 16'h0002);
      chk(16'(n_cmp), 16'h0002);
      $display("test trigger start done");
   endtask
   task automatic t_reset_mode();
      wreg(timer_slave_pkg::ADDR_CTRL, 16'h0000);
      wreg(timer_slave_pkg::ADDR_CNT, 16'h0003);
      wreg(timer_slave_pkg::ADDR_FLAG, 16'h0007);
      wreg(timer_slave_pkg::ADDR_SLAVE, 16'h0064);
      // b falls, a falls, then b rises: the rise clears the stopped counter
      turn(1'b0, 3);
      chk(cnt, timer_slave_pkg::WORD_ZERO);
      rreg(timer_slave_pkg::ADDR_FLAG);
      chk(got & 16'h0003, 16'h0003);
      chk({15'h0, irq}, 16'h0001);
      $display("test reset mode done");
   endtask
   task automatic t_gated_mode();
      logic [15:0] held;
      wreg(timer_slave_pkg::ADDR_SLAVE, 16'h0065);
      repeat (4) @(posedge clk);
      // gate open but enable clear: nothing moves
      chk(cnt, timer_slave_pkg::WORD_ZERO);
      wreg(timer_slave_pkg::ADDR_CTRL, 16'h0001);
      wreg(timer_slave_pkg::ADDR_FLAG, 16'h0007);
      // b falls: the gate shuts and the counter must freeze
      turn(1'b1, 1);
      held = cnt;
      repeat (4) @(posedge clk);
      chk(cnt, held);
      rreg(timer_slave_pkg::ADDR_FLAG);
      chk(got & 16'h0001, 16'h0001);
      $display("test gated mode done");
   endtask
   initial
   begin
      {rst_n, wr, rd, step, fwd} = '0;
      addr = 4'h0;
      wdata = 16'h0000;
      n_fail = 0;
      compares = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_values();
      t_encoder_both();
      t_encoder_one();
      t_trigger_start();
      t_reset_mode();
      t_gated_mode();
      test_done();
   end
endmodule
